// [logic/psfp_defs.svh]
// Purpose: constants for the power state and fault protection block
// Assumes: voltages in mV, currents in A, temperatures in deg C
// Notes: timing counts are derived from the 8 ns clock period
`ifndef PSFP_DEFS_SVH
`define PSFP_DEFS_SVH
// ----------------------------------------
// register map
// ----------------------------------------
`define PSFP_WAKE_LAT_ADDR 8'h2b
// ----------------------------------------
// timing
// ----------------------------------------
`define PSFP_CLK_NS 8
`define PSFP_ON_STEP_NS 40
`define PSFP_ON_STEP_CYC ((`PSFP_ON_STEP_NS + `PSFP_CLK_NS - 1) / `PSFP_CLK_NS)
`define PSFP_ADJ_STEP_NS 60
`define PSFP_ADJ_STEP_CYC ((`PSFP_ADJ_STEP_NS + `PSFP_CLK_NS - 1) / `PSFP_CLK_NS)
// ----------------------------------------
// thresholds
// ----------------------------------------
`define PSFP_OV_RELEASE_MV 13'd248
`define PSFP_UV_ADC_MV 13'd248
`define PSFP_SS_OV0_MV 13'd2500
`define PSFP_SS_OV1_MV 13'd1200
`define PSFP_SS_OV2_MV 13'd1275
`define PSFP_SS_OV3_MV 13'd1350
`define PSFP_STEP_MV 13'd50
`define PSFP_OT_MAX_C 9'd135
`define PSFP_OT_OFS_MAX_C 9'd32
`define PSFP_HICCUP_RETRIES 2'd2
`endif

// [logic/psfp_pkg.sv]
// Purpose: shared types of the power state and fault protection block
// Assumes: nothing beyond the defs header
// Notes: fault vector order is fixed, both flag sets share it
package psfp_pkg;
  // power states
  typedef enum logic [2:0] {
    FULL_POWER_STATE = 3'b000,
    ONE_PHASE_STATE = 3'b001,
    PULSE_SKIP_STATE = 3'b010,
    PULSE_SKIP_LOW_POWER_STATE = 3'b011,
    DEEP_SLEEP_STATE = 3'b100
  } psfp_ps_t;
  // diode emulation sequencer
  typedef enum logic [1:0] {DE_WAIT = 2'b00, DE_HIGH = 2'b01, DE_LOW = 2'b10} psfp_de_t;
  // protection response
  typedef enum logic [1:0] {PR_RUN = 2'b00, PR_HICCUP = 2'b01, PR_SHUT = 2'b10} psfp_pr_t;
  // one flag per fault kind
  typedef struct packed {
    logic ov;
    logic uv;
    logic oc;
    logic slow_oc;
    logic ot;
  } psfp_fault_t;
endpackage : psfp_pkg

// [logic/psfp_ctrl.sv]
// Purpose: light-load states, deep sleep and output protection control
// Assumes: all inputs synchronous to CLK_I, measurements already digital
// Notes: all outputs registered, so a response lands one edge after its cause, two where it passes a state register first
`timescale 1ns/1ps
`default_nettype none
`include "psfp_defs.svh"
module psfp_ctrl
  import psfp_pkg::*;
#(
  parameter int NPH = 8,
  parameter int HICCUP_CYC = 125000,
  parameter int FILT_DIV = 1024,
  parameter logic [7:0] WAKE_LATENCY = 8'h00 // arbitrary value
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic [7:0] LIGHT_LOAD_ENTRY_CURRENT_I,
  input wire logic [7:0] EMULATION_ERROR_LEVEL_I,
  input wire logic [7:0] EMULATION_ON_WIDTH_I,
  input wire logic [7:0] LOW_SIDE_TRIM_I,
  input wire logic [11:0] LOW_SIDE_CALC_I,
  input wire logic [7:0] ERROR_I,
  input wire logic PWM_REQ_I,
  input wire logic PS_CMD_VALID_I,
  input wire logic [2:0] PS_CMD_I,
  input wire logic SET_VOLTAGE_CMD_I,
  input wire logic VOLTAGE_ID_BUS_CLK_I,
  input wire logic WAKE_ON_CLK_I,
  input wire logic SLEEP_RAMP_OR_DECAY_SEL_I,
  input wire logic [7:0] VREG_ADDR_I,
  input wire logic VREG_RD_I,
  input wire logic ENABLE_I,
  input wire logic SOFT_START_I,
  input wire logic VOLTAGE_CODE_DOWN_I,
  input wire logic VOLTAGE_CODE_MOVING_I,
  input wire logic [11:0] VOUT_MV_I,
  input wire logic [11:0] VOLTAGE_CODE_MV_I,
  input wire logic [11:0] DROOP_MV_I,
  input wire logic [2:0] OV_MARGIN_SEL_I,
  input wire logic [1:0] SS_OV_SEL_I,
  input wire logic OV_RELEASE_SEL_I,
  input wire logic GUARD_WHILE_OFF_I,
  input wire logic [2:0] UV_SEL_I,
  input wire logic UV_USE_ADC_I,
  input wire logic UV_DROOP_I,
  input wire logic [NPH-1:0][7:0] PHASE_AMPS_I,
  input wire logic [5:0] OC_LIMIT_I,
  input wire logic [1:0] OC_SCALE_I,
  input wire logic [1:0] OC_MODE_I,
  input wire logic [9:0] OUT_AMPS_I,
  input wire logic [9:0] SLOW_LIMIT_I,
  input wire logic [2:0] FILTER_BW_I,
  input wire logic [7:0] TEMP_C_I,
  input wire logic [7:0] HOT_WARNING_C_I,
  input wire logic [5:0] OT_OFFSET_C_I,
  input wire logic STICKY_CLR_I,
  output logic HS_O,
  output logic LS_O,
  output logic TRI_O,
  output logic RAMP_DOWN_O,
  output logic SENSE_AMP_OFF_O,
  output logic PS_ACK_O,
  output logic [2:0] PS_STATE_O,
  output logic [7:0] VREG_DATA_O,
  output logic REG_RUN_O,
  output psfp_fault_t FAULT_O,
  output psfp_fault_t STICKY_O
);
  // refuse sizes the counters and phase vector cannot serve
  if (NPH < 1 || NPH > 8 || HICCUP_CYC < 1 || FILT_DIV < 1) begin : g_bad_param
    $error("psfp_ctrl bad parameter");
  end
  // ----------------------------------------
  // power state sequencing
  // ----------------------------------------
  psfp_ps_t ps; // present power state
  logic clk_seen; // last sampled bus clock level
  logic skip_ok; // load light enough for skipping
  assign skip_ok = {2'b00, OUT_AMPS_I} < {4'h0, LIGHT_LOAD_ENTRY_CURRENT_I};
  // command decode, sleep exit and entry
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ps <= FULL_POWER_STATE;
      PS_ACK_O <= 1'b0;
      clk_seen <= 1'b0;
    end else begin
      clk_seen <= VOLTAGE_ID_BUS_CLK_I;
      PS_ACK_O <= PS_CMD_VALID_I && PS_CMD_I <= 3'd4;
      if (ps == DEEP_SLEEP_STATE) begin
        // only the configured wake event is honoured
        if (WAKE_ON_CLK_I && (clk_seen != VOLTAGE_ID_BUS_CLK_I)) begin
          ps <= FULL_POWER_STATE;
        end else if (!WAKE_ON_CLK_I && SET_VOLTAGE_CMD_I) begin
          ps <= FULL_POWER_STATE;
        end else if (!WAKE_ON_CLK_I && PS_CMD_VALID_I && PS_CMD_I < 3'd4) begin
          ps <= (PS_CMD_I >= 3'd2 && !skip_ok) ? FULL_POWER_STATE : psfp_ps_t'(PS_CMD_I);
        end
      end else if (PS_CMD_VALID_I && PS_CMD_I <= 3'd4) begin
        // skip states refused while load is heavy
        if (PS_CMD_I == 3'd2 || PS_CMD_I == 3'd3) begin
          if (skip_ok) ps <= psfp_ps_t'(PS_CMD_I);
        end else begin
          ps <= psfp_ps_t'(PS_CMD_I);
        end
      end else if (SET_VOLTAGE_CMD_I && VOLTAGE_CODE_MOVING_I) begin
        ps <= FULL_POWER_STATE; // a voltage move returns to full power
      end
    end
  end
  // ----------------------------------------
  // diode emulation sequencer
  // ----------------------------------------
  psfp_de_t de; // sequencer state
  logic [11:0] de_cnt; // cycles left in phase
  logic in_skip; // pulse skipping active
  logic [11:0] trim_cyc; // low-side reduction in cycles
  logic [11:0] ls_cyc; // trimmed low-side time
  assign in_skip = ps == PULSE_SKIP_STATE || ps == PULSE_SKIP_LOW_POWER_STATE;
  assign trim_cyc = 12'(LOW_SIDE_TRIM_I * `PSFP_ADJ_STEP_CYC);
  // clamp rather than wrap, a long trim just skips the low-side interval
  assign ls_cyc = (LOW_SIDE_CALC_I > trim_cyc) ? LOW_SIDE_CALC_I - trim_cyc : 12'h000;
  // one constant on-time pulse each time the error is at or above the level while waiting
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      de <= DE_WAIT;
      de_cnt <= 12'h000;
    end else begin
      case (de)
        DE_WAIT: begin
          if (in_skip && ERROR_I >= EMULATION_ERROR_LEVEL_I && EMULATION_ON_WIDTH_I != 8'h00) begin
            de <= DE_HIGH;
            de_cnt <= 12'(EMULATION_ON_WIDTH_I * `PSFP_ON_STEP_CYC) - 12'h001;
          end
        end
        DE_HIGH: begin
          if (de_cnt != 12'h000) begin
            de_cnt <= de_cnt - 12'h001;
          end else if (ls_cyc != 12'h000) begin
            de <= DE_LOW;
            de_cnt <= ls_cyc - 12'h001;
          end else begin
            de <= DE_WAIT;
          end
        end
        DE_LOW: begin
          // low-side released at the predicted zero crossing
          if (de_cnt != 12'h000) de_cnt <= de_cnt - 12'h001;
          else de <= DE_WAIT;
        end
        default: de <= DE_WAIT;
      endcase
      if (!in_skip) de <= DE_WAIT;
    end
  end
  // ----------------------------------------
  // over-voltage guard
  // ----------------------------------------
  logic [12:0] ov_lvl; // active trip level
  logic ov_arm; // detection allowed
  logic ov_raw; // level exceeded
  logic ov_hold; // low-side forced on
  logic en_seen; // enable of last cycle
  always_comb begin
    case (SS_OV_SEL_I)
      2'd0: ov_lvl = `PSFP_SS_OV0_MV;
      2'd1: ov_lvl = `PSFP_SS_OV1_MV;
      2'd2: ov_lvl = `PSFP_SS_OV2_MV;
      default: ov_lvl = `PSFP_SS_OV3_MV;
    endcase
    if (!SOFT_START_I) begin
      ov_lvl = {1'b0, VOLTAGE_CODE_MV_I} + 13'((OV_MARGIN_SEL_I + 4'd1) * `PSFP_STEP_MV);
    end
  end
  assign ov_arm = (ENABLE_I || GUARD_WHILE_OFF_I) && !(VOLTAGE_CODE_DOWN_I && !SOFT_START_I);
  assign ov_raw = ov_arm && {1'b0, VOUT_MV_I} > ov_lvl;
  // latched mode holds until an enable toggle, release mode until 248mV
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ov_hold <= 1'b0;
      en_seen <= 1'b0;
    end else begin
      en_seen <= ENABLE_I;
      if (ov_raw) ov_hold <= 1'b1;
      else if (OV_RELEASE_SEL_I && {1'b0, VOUT_MV_I} < `PSFP_OV_RELEASE_MV) ov_hold <= 1'b0;
      else if (!OV_RELEASE_SEL_I && ENABLE_I && !en_seen) ov_hold <= 1'b0;
    end
  end
  // ----------------------------------------
  // under-voltage, current and temperature checks
  // ----------------------------------------
  logic [12:0] uv_lvl; // under-voltage floor
  logic [12:0] uv_ofs; // margin plus optional droop
  logic uv_raw; // output too low
  logic blank; // start or move in progress, or regulator not running
  logic [NPH-1:0] ph_oc; // per-phase trips
  logic [8:0] oc_lim; // scaled phase limit
  logic [19:0] avg; // filtered output current
  logic [$clog2(FILT_DIV+1)-1:0] tick; // filter decimation
  logic [8:0] ot_lvl; // over-temperature level
  logic [8:0] ot_sum; // hot warning plus offset
  assign blank = SOFT_START_I || VOLTAGE_CODE_MOVING_I || !REG_RUN_O;
  assign uv_ofs = 13'((UV_SEL_I + 4'd1) * `PSFP_STEP_MV) + (UV_DROOP_I ? {1'b0, DROOP_MV_I} : 13'h0000);
  always_comb begin
    if (UV_USE_ADC_I) uv_lvl = `PSFP_UV_ADC_MV;
    else if ({1'b0, VOLTAGE_CODE_MV_I} > uv_ofs) uv_lvl = {1'b0, VOLTAGE_CODE_MV_I} - uv_ofs;
    else uv_lvl = 13'h0000;
  end
  assign uv_raw = !blank && {1'b0, VOUT_MV_I} < uv_lvl;
  assign oc_lim = (OC_SCALE_I == 2'd2) ? {1'b0, OC_LIMIT_I, 2'b00} :
                  (OC_SCALE_I == 2'd1) ? {2'b00, OC_LIMIT_I, 1'b0} : {3'b000, OC_LIMIT_I};
  // one comparator per phase
  for (genvar g = 0; g < NPH; g++) begin : g_phase
    assign ph_oc[g] = {1'b0, PHASE_AMPS_I[g]} > oc_lim;
  end
  // wider offsets clamp at 32C, total clamps at 135C
  assign ot_sum = {1'b0, HOT_WARNING_C_I} + ((OT_OFFSET_C_I > 6'd32) ? `PSFP_OT_OFS_MAX_C : {3'b000, OT_OFFSET_C_I});
  assign ot_lvl = (ot_sum > `PSFP_OT_MAX_C) ? `PSFP_OT_MAX_C : ot_sum;
  // decimated first-order filter, wider setting means shorter shift
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      avg <= 20'h00000;
      tick <= '0;
    end else if (tick == ($clog2(FILT_DIV+1))'(FILT_DIV - 1)) begin
      tick <= '0;
      avg <= 20'(avg + 20'(($signed({1'b0, OUT_AMPS_I, 10'h000}) - $signed({1'b0, avg})) >>> (4'd10 - {1'b0, FILTER_BW_I})));
    end else begin
      tick <= tick + 1'b1;
    end
  end
  // ----------------------------------------
  // fault flags
  // ----------------------------------------
  psfp_fault_t rt; // this cycle's faults
  assign rt = '{ov: ov_raw, uv: uv_raw, oc: !blank && |ph_oc, slow_oc: !blank && avg[19:10] > SLOW_LIMIT_I, ot: {1'b0, TEMP_C_I} > ot_lvl};
  // set beats clear so no event is lost
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      FAULT_O <= '0;
      STICKY_O <= '0;
    end else begin
      FAULT_O <= rt;
      STICKY_O <= (STICKY_CLR_I ? '0 : STICKY_O) | rt;
    end
  end
  // ----------------------------------------
  // protection response
  // ----------------------------------------
  psfp_pr_t pr; // response state
  logic [1:0] retries; // hiccups taken
  logic [$clog2(HICCUP_CYC+1)-1:0] off_cnt; // off time left
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      pr <= PR_RUN;
      retries <= 2'd0;
      off_cnt <= '0;
    end else begin
      case (pr)
        PR_RUN: begin
          if (rt.ot) begin
            pr <= PR_SHUT;
          end else if (rt.uv || rt.oc || rt.slow_oc) begin
            // under-voltage shares the current response
            if (OC_MODE_I == 2'd0 || (OC_MODE_I == 2'd1 && retries == `PSFP_HICCUP_RETRIES)) begin
              pr <= PR_SHUT;
            end else begin
              pr <= PR_HICCUP;
              off_cnt <= ($clog2(HICCUP_CYC+1))'(HICCUP_CYC - 1);
              if (retries != 2'd3) retries <= retries + 2'd1;
            end
          end
        end
        PR_HICCUP: begin
          if (off_cnt != '0) off_cnt <= off_cnt - 1'b1;
          else pr <= PR_RUN;
        end
        PR_SHUT: begin
          if (!ENABLE_I) begin
            pr <= PR_RUN;
            retries <= 2'd0;
          end
        end
        default: pr <= PR_RUN;
      endcase
    end
  end
  // ----------------------------------------
  // stage drive and readback
  // ----------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      HS_O <= 1'b0;
      LS_O <= 1'b0;
      TRI_O <= 1'b1;
      RAMP_DOWN_O <= 1'b0;
      SENSE_AMP_OFF_O <= 1'b0;
      PS_STATE_O <= 3'd0;
      VREG_DATA_O <= 8'h00;
      REG_RUN_O <= 1'b0;
    end else begin
      REG_RUN_O <= ENABLE_I && pr == PR_RUN;
      PS_STATE_O <= ps;
      RAMP_DOWN_O <= ps == DEEP_SLEEP_STATE && SLEEP_RAMP_OR_DECAY_SEL_I;
      SENSE_AMP_OFF_O <= ps == PULSE_SKIP_LOW_POWER_STATE;
      if (VREG_RD_I) VREG_DATA_O <= (VREG_ADDR_I == `PSFP_WAKE_LAT_ADDR) ? WAKE_LATENCY : 8'h00;
      if (ov_hold) begin
        {HS_O, LS_O, TRI_O} <= 3'b010;
      end else if (!REG_RUN_O || ps == DEEP_SLEEP_STATE) begin
        {HS_O, LS_O, TRI_O} <= 3'b001;
      end else if (in_skip) begin
        {HS_O, LS_O, TRI_O} <= {de == DE_HIGH, de == DE_LOW, de == DE_WAIT};
      end else begin
        {HS_O, LS_O, TRI_O} <= {PWM_REQ_I, !PWM_REQ_I, 1'b0};
      end
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  logic [11:0] hs_len; // helper: length of a skip pulse
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) hs_len <= 12'h000;
    else if (de == DE_HIGH) hs_len <= hs_len + 12'h001;
    else hs_len <= 12'h000;
  end
  a_sticky_with_rt: assert property ((FAULT_O & ~STICKY_O) == '0) else $error("sticky lags flag");
  a_sticky_keeps: assert property (STICKY_O.ot && !STICKY_CLR_I |=> STICKY_O.ot) else $error("sticky lost");
  a_sleep_ack: assert property (PS_CMD_VALID_I && PS_CMD_I == 3'd4 |=> PS_ACK_O) else $error("no ack");
  a_sleep_tristate: assert property (ps == DEEP_SLEEP_STATE && !ov_hold |=> TRI_O && !HS_O) else $error("not tristated");
  a_ov_low_side: assert property (ov_hold |=> LS_O && !HS_O && !TRI_O) else $error("low-side not forced");
  a_ov_down_blank: assert property (VOLTAGE_CODE_DOWN_I && !SOFT_START_I |-> !ov_raw ##1 !FAULT_O.ov) else $error("ov during down move");
  a_oc_blanking: assert property (SOFT_START_I || VOLTAGE_CODE_MOVING_I |=> !FAULT_O.oc && !FAULT_O.slow_oc) else $error("oc not blanked");
  a_on_width: assert property (de == DE_HIGH && de_cnt == 12'h000 |-> hs_len == 12'(EMULATION_ON_WIDTH_I * `PSFP_ON_STEP_CYC) - 12'h001) else $error("on width wrong");
  a_skip_gate: assert property (!in_skip ##1 in_skip |-> $past(skip_ok)) else $error("skip with heavy load");
  a_ot_latch: assert property (pr == PR_RUN && rt.ot |=> pr == PR_SHUT ##1 !REG_RUN_O) else $error("ot not latched");
  a_clock_wake: assert property (ps == DEEP_SLEEP_STATE && WAKE_ON_CLK_I && clk_seen != VOLTAGE_ID_BUS_CLK_I |=> ps == FULL_POWER_STATE) else $error("no wake");
  c_sleep: cover property (ps != DEEP_SLEEP_STATE ##1 ps == DEEP_SLEEP_STATE);
  c_hiccup: cover property (pr == PR_HICCUP ##1 pr == PR_RUN);
  c_de_pulse: cover property (de == DE_HIGH ##1 de == DE_LOW);
  c_ov_release: cover property (ov_hold ##1 !ov_hold);
endmodule : psfp_ctrl
`default_nettype wire

// [test/psfp_stage_model.sv]
// Purpose: behavioural tri-state power stage seen by the controller
// Assumes: one stage stands for all phases, driven by HS_O, LS_O, TRI_O
// Notes: measures pulse lengths so the bench can judge the on/off timing
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// stage model
// ----------------------------------------
module psfp_stage_model (
  input wire logic clk_i,
  input wire logic hs_i,
  input wire logic ls_i,
  input wire logic tri_i,
  output logic node_o,
  output logic [15:0] hs_len_o,
  output logic [15:0] ls_len_o
);
  logic hs_q = 1'b0; // previous high-side level
  initial hs_len_o = 16'h0;
  initial ls_len_o = 16'h0;
  initial node_o = 1'b0;
  // length counters restart on each new high-side pulse
  always @(posedge clk_i) begin
    hs_q <= hs_i;
    if (hs_i && !hs_q) begin
      hs_len_o <= 16'h1;
      ls_len_o <= 16'h0;
    end else begin
      if (hs_i) begin
        hs_len_o <= hs_len_o + 16'h1;
      end
      if (ls_i && !tri_i) begin
        ls_len_o <= ls_len_o + 16'h1;
      end
    end
    // floating node never repeats its last level, so no stale value reads as real
    node_o <= tri_i ? ~node_o : hs_i;
  end
endmodule : psfp_stage_model
`default_nettype wire

// [test/tb.sv]
// Purpose: self-checking bench for the power state and fault control
// Assumes: short hiccup and filter counts for a quick run
// Notes: expectations come from integer models in this file
`timescale 1ns/1ps
`default_nettype none
module tb;
  import psfp_pkg::*;
  localparam logic [7:0] WAKE_CODE = 8'h5a; // arbitrary value
  // ----------------------------------------
  // stimulus and observation
  // ----------------------------------------
  logic CLK_I = 1'b0, RST_N_I = 1'b0, PWM_REQ_I = 1'b0, PS_CMD_VALID_I = 1'b0;
  logic SET_VOLTAGE_CMD_I = 1'b0, VOLTAGE_ID_BUS_CLK_I = 1'b0, WAKE_ON_CLK_I = 1'b1;
  logic SLEEP_RAMP_OR_DECAY_SEL_I = 1'b1, VREG_RD_I = 1'b0, ENABLE_I = 1'b1;
  logic SOFT_START_I = 1'b0, VOLTAGE_CODE_DOWN_I = 1'b0, VOLTAGE_CODE_MOVING_I = 1'b0;
  logic OV_RELEASE_SEL_I = 1'b1, GUARD_WHILE_OFF_I = 1'b0, UV_USE_ADC_I = 1'b0;
  logic UV_DROOP_I = 1'b0, STICKY_CLR_I = 1'b0;
  logic [7:0] LIGHT_LOAD_ENTRY_CURRENT_I = 8'h0a, EMULATION_ERROR_LEVEL_I = 8'h14;
  logic [7:0] EMULATION_ON_WIDTH_I = 8'h03, LOW_SIDE_TRIM_I = 8'h02, ERROR_I = 8'h00;
  logic [7:0] TEMP_C_I = 8'h28, HOT_WARNING_C_I = 8'h50, VREG_ADDR_I = 8'h00;
  logic [11:0] LOW_SIDE_CALC_I = 12'h028, VOUT_MV_I = 12'h3e8;
  logic [11:0] VOLTAGE_CODE_MV_I = 12'h3e8, DROOP_MV_I = 12'h000;
  logic [2:0] PS_CMD_I = 3'h0, OV_MARGIN_SEL_I = 3'h1, UV_SEL_I = 3'h1, FILTER_BW_I = 3'h0;
  logic [1:0] SS_OV_SEL_I = 2'h0, OC_SCALE_I = 2'h0, OC_MODE_I = 2'h0;
  logic [5:0] OC_LIMIT_I = 6'h1e, OT_OFFSET_C_I = 6'h0a;
  logic [9:0] OUT_AMPS_I = 10'h003, SLOW_LIMIT_I = 10'h3ff;
  logic [1:0][7:0] PHASE_AMPS_I = {8'h05, 8'h05};
  logic HS_O, LS_O, TRI_O, RAMP_DOWN_O, SENSE_AMP_OFF_O, PS_ACK_O, REG_RUN_O;
  logic [2:0] PS_STATE_O;
  logic [7:0] VREG_DATA_O;
  psfp_fault_t FAULT_O, STICKY_O;
  logic [15:0] hs_len, ls_len; // pulse lengths seen by the stage
  int num_errors = 0, compares = 0, cycles = 0, seed = 65, v, rises;
  logic prev_run;
  psfp_ctrl #(.NPH(2), .HICCUP_CYC(20), .FILT_DIV(4), .WAKE_LATENCY(WAKE_CODE)) dut (.*);
  psfp_stage_model stage (.clk_i(CLK_I), .hs_i(HS_O), .ls_i(LS_O), .tri_i(TRI_O),
    .node_o(), .hs_len_o(hs_len), .ls_len_o(ls_len));
  // clock and hang guard; a hang counts as a mismatch
  initial forever #4 CLK_I = ~CLK_I;
  always @(posedge CLK_I) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      report_and_stop();
    end
  end
  // ----------------------------------------
  // integer models and helpers
  // ----------------------------------------
  function automatic int ov_thr(int code_mv, int sel);
    return code_mv + (sel + 1) * 50;
  endfunction : ov_thr
  function automatic int ot_lim(int hot, int ofs);
    int o;
    o = (ofs > 32) ? 32 : ofs;
    return (hot + o > 135) ? 135 : hot + o;
  endfunction : ot_lim
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chk_f(input psfp_fault_t got, input psfp_fault_t exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: flags %b expected %b", $time, got, exp);
    end
  endtask : chk_f
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_I);
  endtask : cyc
  // power command: ack one cycle later, state one after that
  task automatic ps_cmd(input logic [2:0] c, input logic [2:0] st, input logic ack);
    @(posedge CLK_I);
    PS_CMD_VALID_I <= 1'b1;
    PS_CMD_I <= c;
    @(posedge CLK_I);
    PS_CMD_VALID_I <= 1'b0;
    @(negedge CLK_I);
    chk(PS_ACK_O, ack);
    @(negedge CLK_I);
    chk(PS_STATE_O, st);
  endtask : ps_cmd
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge CLK_I);
    VREG_ADDR_I <= a;
    VREG_RD_I <= 1'b1;
    @(posedge CLK_I);
    VREG_RD_I <= 1'b0;
    @(negedge CLK_I);
    chk(VREG_DATA_O, exp);
  endtask : rd
  task automatic en_cycle();
    @(posedge CLK_I);
    ENABLE_I <= 1'b0;
    cyc(3);
    ENABLE_I <= 1'b1;
    cyc(6);
  endtask : en_cycle
  task automatic report_and_stop();
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    cyc(8);
    RST_N_I <= 1'b1;
    cyc(1);
    @(negedge CLK_I);
    chk(TRI_O, 1'b1);
    chk_f(STICKY_O, '0);
    // one edge later the run flag is up and the main loop drives the stage
    @(negedge CLK_I);
    chk(LS_O, 1'b1);
    rd(8'h2b, WAKE_CODE);
    for (int i = 0; i < 3; i++) begin
      v = $random(seed);
      rd((v[7:0] == 8'h2b) ? 8'h00 : v[7:0], 8'h00);
    end
    // sleep with ramp-down, wake on a bus clock toggle
    ps_cmd(3'h4, 3'h4, 1'b1);
    chk(TRI_O, 1'b1);
    chk(RAMP_DOWN_O, 1'b1);
    @(posedge CLK_I);
    VOLTAGE_ID_BUS_CLK_I <= 1'b1;
    cyc(3);
    @(negedge CLK_I);
    chk(PS_STATE_O, 3'h0);
    // decay mode: a toggle must not wake, commands must
    @(posedge CLK_I);
    WAKE_ON_CLK_I <= 1'b0;
    SLEEP_RAMP_OR_DECAY_SEL_I <= 1'b0;
    ps_cmd(3'h4, 3'h4, 1'b1);
    chk(RAMP_DOWN_O, 1'b0);
    @(posedge CLK_I);
    VOLTAGE_ID_BUS_CLK_I <= 1'b0;
    cyc(4);
    SET_VOLTAGE_CMD_I <= 1'b1;
    @(negedge CLK_I);
    chk(PS_STATE_O, 3'h4);
    @(posedge CLK_I);
    SET_VOLTAGE_CMD_I <= 1'b0;
    cyc(2);
    @(negedge CLK_I);
    chk(PS_STATE_O, 3'h0);
    for (int c = 0; c < 4; c++) begin
      ps_cmd(3'h4, 3'h4, 1'b1);
      ps_cmd(3'(c), 3'(c), 1'b1);
    end
    chk(SENSE_AMP_OFF_O, 1'b1);
    ps_cmd(3'h5, 3'h3, 1'b0);
    ps_cmd(3'h0, 3'h0, 1'b1);
    // heavy load refuses the skip states
    @(posedge CLK_I);
    OUT_AMPS_I <= 10'h014;
    ps_cmd(3'h2, 3'h0, 1'b1);
    @(posedge CLK_I);
    OUT_AMPS_I <= 10'h003;
    ps_cmd(3'h2, 3'h2, 1'b1);
    // one emulation pulse per setting; second row trims low side to nothing
    for (int i = 0; i < 2; i++) begin
      @(posedge CLK_I);
      EMULATION_ON_WIDTH_I <= i ? 8'h01 : 8'h03;
      LOW_SIDE_TRIM_I <= i ? 8'h06 : 8'h02;
      ERROR_I <= i ? 8'h14 : 8'h1e;
      for (int k = 0; k < 20 && HS_O !== 1'b1; k++) cyc(1);
      ERROR_I <= 8'h00;
      cyc(80);
      @(negedge CLK_I);
      chk(hs_len, i ? 16'd5 : 16'd15);
      chk(ls_len, i ? 16'd0 : 16'd24);
    end
    ps_cmd(3'h0, 3'h0, 1'b1);
    // over-voltage around the margin, boundary first
    for (int i = 0; i < 10; i++) begin
      @(posedge CLK_I);
      v = (i < 2) ? 1100 + i : 1040 + {$random(seed)} % 121;
      VOUT_MV_I <= 12'(v);
      cyc(2);
      @(negedge CLK_I);
      chk(FAULT_O.ov, v > ov_thr(1000, 1));
    end
    @(posedge CLK_I);
    VOUT_MV_I <= 12'h47e;
    cyc(4);
    @(negedge CLK_I);
    chk(LS_O, 1'b1);
    @(posedge CLK_I);
    VOUT_MV_I <= 12'h3e8;
    cyc(3);
    @(negedge CLK_I);
    chk(STICKY_O.ov, 1'b1);
    // release mode: low-side let go once the output sinks below 248mV
    @(posedge CLK_I);
    SOFT_START_I <= 1'b1;
    PWM_REQ_I <= 1'b1;
    VOUT_MV_I <= 12'h0c8;
    cyc(3);
    @(negedge CLK_I);
    chk(HS_O, 1'b1);
    @(posedge CLK_I);
    SOFT_START_I <= 1'b0;
    PWM_REQ_I <= 1'b0;
    VOUT_MV_I <= 12'h3e8;
    @(posedge CLK_I);
    STICKY_CLR_I <= 1'b1;
    VOLTAGE_CODE_DOWN_I <= 1'b1;
    VOUT_MV_I <= 12'h4b0;
    @(posedge CLK_I);
    STICKY_CLR_I <= 1'b0;
    cyc(3);
    @(negedge CLK_I);
    chk_f(FAULT_O, '0);
    chk_f(STICKY_O, '0);
    // under-voltage: ADC floor, then each response mode
    @(posedge CLK_I);
    VOLTAGE_CODE_DOWN_I <= 1'b0;
    UV_USE_ADC_I <= 1'b1;
    VOUT_MV_I <= 12'h352;
    cyc(4);
    @(negedge CLK_I);
    chk(FAULT_O.uv, 1'b0);
    for (int m = 0; m < 3; m++) begin
      @(posedge CLK_I);
      VOUT_MV_I <= 12'h3e8;
      UV_USE_ADC_I <= 1'b0;
      OC_MODE_I <= 2'(m);
      en_cycle();
      VOUT_MV_I <= 12'h352;
      rises = 0;
      prev_run = 1'b1;
      repeat (300) begin
        @(negedge CLK_I);
        if (REG_RUN_O === 1'b1 && prev_run !== 1'b1) rises++;
        prev_run = REG_RUN_O;
      end
      chk(16'((rises > 3) ? 3 : rises), 16'(m == 0 ? 0 : m == 1 ? 2 : 3));
    end
    // fast current limit: doubled, blanked while moving, then trips
    @(posedge CLK_I);
    VOUT_MV_I <= 12'h3e8;
    OC_MODE_I <= 2'h0;
    // let a pending hiccup run out before the enable cycle
    cyc(24);
    en_cycle();
    PHASE_AMPS_I[1] <= 8'h28;
    OC_SCALE_I <= 2'h1;
    cyc(4);
    OC_SCALE_I <= 2'h0;
    VOLTAGE_CODE_MOVING_I <= 1'b1;
    @(negedge CLK_I);
    chk(FAULT_O.oc, 1'b0);
    cyc(4);
    VOLTAGE_CODE_MOVING_I <= 1'b0;
    @(negedge CLK_I);
    chk(FAULT_O.oc, 1'b0);
    // real-time flag stands only until the shutdown blanks it
    @(negedge CLK_I);
    chk(FAULT_O.oc, 1'b1);
    cyc(2);
    @(negedge CLK_I);
    chk(REG_RUN_O, 1'b0);
    // slow limit: averaged load above a low limit shuts down
    @(posedge CLK_I);
    PHASE_AMPS_I[1] <= 8'h05;
    FILTER_BW_I <= 3'h7;
    SLOW_LIMIT_I <= 10'h001;
    en_cycle();
    cyc(200);
    @(negedge CLK_I);
    chk(STICKY_O.slow_oc, 1'b1);
    chk(REG_RUN_O, 1'b0);
    // over-voltage guard while disabled only when the option is set
    @(posedge CLK_I);
    SLOW_LIMIT_I <= 10'h3ff;
    ENABLE_I <= 1'b0;
    VOUT_MV_I <= 12'h4b0;
    cyc(2);
    @(negedge CLK_I);
    chk(FAULT_O.ov, 1'b0);
    @(posedge CLK_I);
    GUARD_WHILE_OFF_I <= 1'b1;
    cyc(2);
    @(negedge CLK_I);
    chk(FAULT_O.ov, 1'b1);
    // over-temperature: offset clamp, trip, latch until enable toggles
    @(posedge CLK_I);
    GUARD_WHILE_OFF_I <= 1'b0;
    VOUT_MV_I <= 12'h3e8;
    en_cycle();
    OT_OFFSET_C_I <= 6'h28;
    TEMP_C_I <= 8'h64;
    cyc(4);
    OT_OFFSET_C_I <= 6'h0a;
    @(negedge CLK_I);
    chk(FAULT_O.ot, 100 > ot_lim(80, 40));
    cyc(4);
    TEMP_C_I <= 8'h28;
    @(negedge CLK_I);
    chk(FAULT_O.ot, 100 > ot_lim(80, 10));
    cyc(10);
    @(negedge CLK_I);
    chk(REG_RUN_O, 1'b0);
    en_cycle();
    @(negedge CLK_I);
    chk(REG_RUN_O, 1'b1);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
